// file: src/osl_link.sv
`timescale 1ns/1ps
`include "osl_defines.svh"

module osl_link
    import osl_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_rst_b,
    input  wire logic            i_isolated_link_clock,
    input  wire logic            i_isolated_data_in,
    output logic                 o_isolated_data_out,
    output logic                 o_isolated_clear_to_send,
    input  wire logic            i_cfg_chan_a_en,
    input  wire logic            i_cfg_chan_b_en,
    input  wire logic            i_mode_valid,
    input  wire logic [`OSL_CMD_W-1:0] i_mode_cmd,
    output logic                 o_pins_on_chan_b,
    output logic                 o_link_enabled,
    output logic                 o_link_held,
    input  wire logic            i_tx_valid,
    output logic                 o_tx_ready,
    input  wire osl_byte_t       i_tx_data,
    input  wire logic            i_tx_chan,
    output logic                 o_rx_valid,
    input  wire logic            i_rx_ready,
    output osl_byte_t            o_rx_data,
    output logic                 o_rx_chan
);

    // ---------------------------------------------------------------
    // system side: configuration and mode
    // ---------------------------------------------------------------
    logic cfg_done;
    logic en_a;
    logic en_b;
    logic hold;
    logic next_cfg_done;
    logic next_en_a;
    logic next_en_b;
    logic next_hold;
    logic enabled;

    // enables are caught once, on the first edge after reset release
    always_comb begin
        next_cfg_done = 1'b1;
        next_en_a     = en_a;
        next_en_b     = en_b;
        next_hold     = hold;
        if (!cfg_done) begin
            next_en_a = i_cfg_chan_a_en;
            next_en_b = i_cfg_chan_b_en;
        end
        if (i_mode_valid) begin
            if (i_mode_cmd == `OSL_CMD_HOLD) begin
                next_hold = 1'b1;
            end else if (i_mode_cmd == `OSL_CMD_RUN) begin
                next_hold = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_done <= 1'b0;
            en_a     <= 1'b0;
            en_b     <= 1'b0;
            hold     <= 1'b0;
        end else begin
            cfg_done <= next_cfg_done;
            en_a     <= next_en_a;
            en_b     <= next_en_b;
            hold     <= next_hold;
        end
    end

    assign enabled          = cfg_done && (en_a || en_b);
    assign o_link_enabled   = enabled;
    assign o_pins_on_chan_b = enabled;
    assign o_link_held      = hold;

    // ---------------------------------------------------------------
    // system side: outgoing word handshake
    // ---------------------------------------------------------------
    logic      tx_req;
    osl_byte_t tx_data;
    logic      tx_src;
    logic      next_tx_req;
    osl_byte_t next_tx_data;
    logic      next_tx_src;
    logic [1:0] tx_ack_sync;
    logic      tx_busy;

    assign tx_busy    = (tx_req != tx_ack_sync[1]);
    // words are taken even while held; they wait in the handshake stage
    assign o_tx_ready = enabled && !tx_busy;

    always_comb begin
        next_tx_req  = tx_req;
        next_tx_data = tx_data;
        next_tx_src  = tx_src;
        if (i_tx_valid && o_tx_ready) begin
            next_tx_req  = !tx_req;
            next_tx_data = i_tx_data;
            next_tx_src  = i_tx_chan;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_req  <= 1'b0;
            tx_data <= '0;
            tx_src  <= `OSL_CHAN_A;
        end else begin
            tx_req  <= next_tx_req;
            tx_data <= next_tx_data;
            tx_src  <= next_tx_src;
        end
    end

    // ---------------------------------------------------------------
    // system side: incoming word handshake and buffer
    // ---------------------------------------------------------------
    logic       rx_ack;
    logic       next_rx_ack;
    logic [1:0] rx_req_sync;
    logic       rx_pend;
    logic       buf_in_ready;
    logic       rx_chan_routed;
    logic       rx_destination_channel_bit_word;
    osl_byte_t  rx_word;
    logic [`OSL_DATA_BITS:0] buf_out;
    logic       tx_ack_l;
    logic       rx_req_l;

    assign rx_pend = (rx_req_sync[1] != rx_ack) && cfg_done;

    // a channel not in this mode hands its byte to the other one
    always_comb begin
        if (rx_destination_channel_bit_word == `OSL_CHAN_A) begin
            rx_chan_routed = en_a ? `OSL_CHAN_A : `OSL_CHAN_B;
        end else begin
            rx_chan_routed = en_b ? `OSL_CHAN_B : `OSL_CHAN_A;
        end
    end

    always_comb begin
        next_rx_ack = rx_ack;
        if (rx_pend && buf_in_ready) begin
            next_rx_ack = !rx_ack;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_ack <= 1'b0;
        end else begin
            rx_ack <= next_rx_ack;
        end
    end

    // toggles from the link side; the first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_ack_sync <= '0;
            rx_req_sync <= '0;
        end else begin
            tx_ack_sync <= {tx_ack_sync[0], tx_ack_l};
            rx_req_sync <= {rx_req_sync[0], rx_req_l};
        end
    end

    osl_buf2 #(
        .WIDTH (`OSL_DATA_BITS + 1),
        .DEPTH (`OSL_BUF_DEPTH)
    ) u_rx_buf (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (rx_pend),
        .o_in_ready  (buf_in_ready),
        .i_in_data   ({rx_chan_routed, rx_word}),
        .o_out_valid (o_rx_valid),
        .i_out_ready (i_rx_ready),
        .o_out_data  (buf_out)
    );

    assign o_rx_data = buf_out[`OSL_DATA_BITS-1:0];
    assign o_rx_chan = buf_out[`OSL_DATA_BITS];

    // ---------------------------------------------------------------
    // link side: synchronisers
    // ---------------------------------------------------------------
    // bit order: space, hold, enable, rx ack, tx req, data in
    localparam int NS = 6;
    logic [NS-1:0] lsync1;
    logic [NS-1:0] lsync2;
    logic          din_l;
    logic          tx_req_l;
    logic          rx_ack_l;
    logic          en_l;
    logic          hold_l;
    logic          space_l;

    always_ff @(posedge i_isolated_link_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lsync1 <= {NS{1'b0}} | NS'(1); // data in idles high
            lsync2 <= {NS{1'b0}} | NS'(1);
        end else begin
            lsync1 <= {buf_in_ready, hold, enabled,
                       rx_ack, tx_req, i_isolated_data_in};
            lsync2 <= lsync1;
        end
    end

    assign {space_l, hold_l, en_l, rx_ack_l, tx_req_l, din_l} = lsync2;

    // ---------------------------------------------------------------
    // link side: frame engine
    // ---------------------------------------------------------------
    osl_link_state_e         state;
    osl_link_state_e         next_state;
    logic [`OSL_CNT_W-1:0]   cnt;
    logic [`OSL_CNT_W-1:0]   next_cnt;
    osl_byte_t               shift;
    osl_byte_t               next_shift;
    logic                    dout;
    logic                    next_dout;
    logic                    cts;
    logic                    next_cts;
    logic                    next_tx_ack_l;
    logic                    next_rx_req_l;
    osl_byte_t               rx_byte_l;
    osl_byte_t               next_rx_byte_l;
    logic                    rx_destination_channel_bit_l;
    logic                    next_rx_destination_channel_bit_l;
    logic                    tx_pend_l;
    logic                    rx_free_l;

    // the far end owns this clock; it may stop it mid-frame to stall
    assign tx_pend_l = (tx_req_l != tx_ack_l);
    assign rx_free_l = (rx_req_l == rx_ack_l);

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_shift     = shift;
        next_dout      = dout;
        next_cts       = cts;
        next_tx_ack_l  = tx_ack_l;
        next_rx_req_l  = rx_req_l;
        next_rx_byte_l = rx_byte_l;
        next_rx_destination_channel_bit_l = rx_destination_channel_bit_l;
        unique case (state)
            OSL_L_IDLE: begin
                next_dout = `OSL_IDLE_LVL;
                next_cnt  = `OSL_CNT_ZERO;
                // reception wins, so no frame starts over one
                if (!en_l) begin
                    next_cts = 1'b0;
                end else if (cts && din_l == `OSL_START_LVL) begin
                    next_state = OSL_L_RX;
                    next_cts   = 1'b0;
                end else if (tx_pend_l && !hold_l) begin
                    next_state = OSL_L_TX;
                    next_dout  = `OSL_START_LVL;
                    next_shift = tx_data;
                    next_cts   = 1'b0;
                end else begin
                    // one byte in flight and no buffer room keep it low
                    next_cts = rx_free_l && space_l;
                end
            end
            OSL_L_TX: begin
                next_cnt = cnt + `OSL_CNT_ONE;
                if (cnt < `OSL_CNT_TAG) begin
                    next_dout  = shift[0];
                    next_shift = {1'b0, shift[7:1]};
                end else if (cnt == `OSL_CNT_TAG) begin
                    next_dout = tx_src;
                end else begin
                    next_dout     = `OSL_IDLE_LVL;
                    next_tx_ack_l = !tx_ack_l;
                    next_state    = OSL_L_IDLE;
                end
            end
            OSL_L_RX: begin
                next_cnt = cnt + `OSL_CNT_ONE;
                if (cnt < `OSL_CNT_TAG) begin
                    next_shift = {din_l, shift[7:1]};
                end else begin
                    next_rx_destination_channel_bit_l = din_l;
                    next_rx_byte_l = shift;
                    next_rx_req_l  = !rx_req_l;
                    next_state     = OSL_L_IDLE;
                end
            end
            default: begin
                next_state = OSL_L_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_isolated_link_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state     <= OSL_L_IDLE;
            cnt       <= `OSL_CNT_ZERO;
            shift     <= '0;
            dout      <= `OSL_IDLE_LVL;
            cts       <= 1'b0;
            tx_ack_l  <= 1'b0;
            rx_req_l  <= 1'b0;
            rx_byte_l <= '0;
            rx_destination_channel_bit_l <= `OSL_CHAN_A;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            shift     <= next_shift;
            dout      <= next_dout;
            cts       <= next_cts;
            tx_ack_l  <= next_tx_ack_l;
            rx_req_l  <= next_rx_req_l;
            rx_byte_l <= next_rx_byte_l;
            rx_destination_channel_bit_l <= next_rx_destination_channel_bit_l;
        end
    end

    // word is stable while its request toggle is unanswered
    assign rx_word      = rx_byte_l;
    assign rx_destination_channel_bit_word = rx_destination_channel_bit_l;

    assign o_isolated_data_out      = dout;
    assign o_isolated_clear_to_send = cts;

endmodule

// file: src/osl_defines.svh
`ifndef OSL_DEFINES_SVH
`define OSL_DEFINES_SVH

// frame layout
`define OSL_DATA_BITS   8
`define OSL_CNT_W       4
`define OSL_CNT_TAG     4'h8
`define OSL_CNT_LAST    4'h9
`define OSL_CNT_ZERO    4'h0
`define OSL_CNT_ONE     4'h1
`define OSL_START_LVL   1'b0
`define OSL_IDLE_LVL    1'b1

// channel codes carried in the tag bit
`define OSL_CHAN_A      1'b0
`define OSL_CHAN_B      1'b1

// mode command values
`define OSL_CMD_W       8
`define OSL_CMD_HOLD    8'h10
`define OSL_CMD_RUN     8'h00

// receive buffer
`define OSL_BUF_DEPTH   2

`endif

// file: src/osl_pkg.sv
package osl_pkg;

    typedef enum logic [1:0] {
        OSL_L_IDLE,
        OSL_L_TX,
        OSL_L_RX
    } osl_link_state_e;

    typedef logic [7:0] osl_byte_t;

endpackage

// file: src/osl_buf2.sv
`timescale 1ns/1ps
`include "osl_defines.svh"

module osl_buf2 #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `OSL_BUF_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count != CW'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage carries no reset; valid is guarded by count
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

endmodule

// file: verification/osl_link_asserts.sv
`timescale 1ns/1ps
`include "osl_defines.svh"
// ----------------------------------------
// port checks, link and user domains
// ----------------------------------------
module osl_link_asserts (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_isolated_link_clock,
    input wire logic       i_isolated_data_in,
    input wire logic       o_isolated_data_out,
    input wire logic       o_isolated_clear_to_send,
    input wire logic       i_mode_valid,
    input wire logic [7:0] i_mode_cmd,
    input wire logic       o_pins_on_chan_b,
    input wire logic       o_link_enabled,
    input wire logic       o_link_held,
    input wire logic       i_tx_valid,
    input wire logic       o_tx_ready,
    input wire logic       o_rx_valid,
    input wire logic       i_rx_ready,
    input wire logic       o_rx_chan
);
    wire lk   = i_isolated_link_clock;
    wire din  = i_isolated_data_in;
    wire dout = o_isolated_data_out;
    wire cts  = o_isolated_clear_to_send;

    // sync stages on data-in give a short window, not one edge
    property p_cts_drop;
        @(posedge lk) disable iff (!i_rst_b)
        cts && $fell(din) |-> ##[2:4] !cts;
    endproperty
    a_cts_drop: assert property (p_cts_drop)
        else $error("clear-to-send stayed high after start");
    property p_rx_no_tx;
        @(posedge lk) disable iff (!i_rst_b) cts && $fell(din) |=> dout [*8];
    endproperty
    a_rx_no_tx: assert property (p_rx_no_tx)
        else $error("frame sent during reception");
    property p_frame;
        @(posedge lk) disable iff (!i_rst_b) $fell(dout) |-> ##10 dout;
    endproperty
    a_frame: assert property (p_frame)
        else $error("outgoing frame not back to idle");
    property p_held_quiet;
        @(posedge lk) disable iff (!i_rst_b)
        $past(o_link_held, 4) && o_link_held |-> !$fell(dout);
    endproperty
    a_held_quiet: assert property (p_held_quiet)
        else $error("frame started while held");
    property p_hold_set;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_mode_valid && i_mode_cmd == `OSL_CMD_HOLD |=> o_link_held;
    endproperty
    a_hold_set: assert property (p_hold_set)
        else $error("hold command not taken");
    property p_tx_one;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_tx_valid && o_tx_ready |=> !o_tx_ready [*2];
    endproperty
    a_tx_one: assert property (p_tx_one)
        else $error("second byte taken while one in flight");
    property p_off;
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_link_enabled |-> !o_tx_ready && !o_pins_on_chan_b && !cts;
    endproperty
    a_off: assert property (p_off)
        else $error("disabled link still active");
    property p_rx_keep;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_chan);
    endproperty
    a_rx_keep: assert property (p_rx_keep)
        else $error("stalled word lost");
    cover property (@(posedge lk) $fell(dout));
    cover property (@(posedge lk) cts && $fell(din));
    cover property (@(posedge i_clk) o_rx_valid && !i_rx_ready);
endmodule

bind osl_link osl_link_asserts osl_link_asserts_i (
    .i_clk, .i_rst_b, .i_isolated_link_clock, .i_isolated_data_in,
    .o_isolated_data_out, .o_isolated_clear_to_send, .i_mode_valid,
    .i_mode_cmd, .o_pins_on_chan_b, .o_link_enabled, .o_link_held,
    .i_tx_valid, .o_tx_ready, .o_rx_valid, .i_rx_ready, .o_rx_chan
);

// file: verification/osl_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far device: link clock and serial ends
// ----------------------------------------
module osl_far_model (
    input  wire logic i_run,
    input  wire logic i_data_out,
    input  wire logic i_cts,
    output logic      o_clk,
    output logic      o_data_in
);
    logic stall = 1'b0;
    int   fails = 0;

    initial begin
        o_clk = 1'b0;
        o_data_in = 1'b1; // open collector: released line sits high
    end

    // parks low when stalled so no half-width pulse escapes
    always #24 if ((i_run && !stall) || o_clk) o_clk = ~o_clk;

    task automatic send(input logic [7:0] b, input logic destination_channel_bit);
        logic [10:0] f;
        int          n;
        f = {1'b1, destination_channel_bit, b, 1'b0};
        for (n = 0; n < 400; n++) begin
            @(negedge o_clk);
            if (i_cts === 1'b1) break;
        end
        if (n == 400) fails++;
        for (int i = 0; i < 11 && n < 400; i++) begin
            if (i > 0) @(negedge o_clk);
            o_data_in = f[i];
        end
    endtask

    task automatic recv(input int stall_ns, output logic [8:0] w);
        int n;
        w = 9'h1ff;
        for (n = 0; n < 400; n++) begin
            @(negedge o_clk);
            if (i_data_out === 1'b0) break;
        end
        if (n == 400) fails++;
        stall = (stall_ns > 0);
        #(stall_ns);
        stall = 1'b0;
        for (int i = 0; i < 9 && n < 400; i++) begin
            @(negedge o_clk);
            w[i] = i_data_out;
        end
    endtask
endmodule

// file: verification/osl_link_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench top
// ----------------------------------------
module osl_link_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, a_en = 1'b0, b_en = 1'b0;
    logic m_valid = 1'b0, tx_valid = 1'b0, tx_chan = 1'b0, rx_ready = 1'b0;
    logic [7:0] m_cmd = 8'h00, tx_data = 8'h00, rx_data;
    logic lk, din, dout, cts, tx_ready, rx_valid, rx_chan, pins_b, en, held;
    logic [8:0] w;
    logic [1:0] s;
    int bad_count = 0, checked = 0;

    osl_link osl_link_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_isolated_link_clock(lk),
        .i_isolated_data_in(din), .o_isolated_data_out(dout),
        .o_isolated_clear_to_send(cts), .i_cfg_chan_a_en(a_en),
        .i_cfg_chan_b_en(b_en), .i_mode_valid(m_valid), .i_mode_cmd(m_cmd),
        .o_pins_on_chan_b(pins_b), .o_link_enabled(en), .o_link_held(held),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data),
        .i_tx_chan(tx_chan), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
        .o_rx_data(rx_data), .o_rx_chan(rx_chan)
    );
    osl_far_model far_i (
        .i_run(run), .i_data_out(dout), .i_cts(cts), .o_clk(lk),
        .o_data_in(din)
    );

    always #10 clk = ~clk;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] e, g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic do_reset(input logic a, input logic b);
        rst_b = 1'b0;
        a_en = a;
        b_en = b;
        run = 1'b1;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (20) @(negedge clk);
    endtask

    task automatic mode(input logic [7:0] c);
        @(negedge clk);
        m_valid = 1'b1;
        m_cmd = c;
        @(negedge clk);
        m_valid = 1'b0;
        @(negedge clk);
    endtask

    // a hung handshake ends the run rather than the watchdog
    task automatic push(input logic [7:0] b, input logic c);
        int n;
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data = b;
        tx_chan = c;
        for (n = 0; n < 2000 && tx_ready !== 1'b1; n++) @(negedge clk);
        if (n == 2000) bad_count++;
        if (n == 2000) give_verdict();
        @(negedge clk);
        tx_valid = 1'b0;
    endtask

    task automatic pop(output logic [8:0] r);
        int n;
        @(negedge clk);
        for (n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(negedge clk);
        if (n == 2000) bad_count++;
        if (n == 2000) give_verdict();
        r = {rx_chan, rx_data};
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask

    task automatic rx1(input logic [7:0] b, input logic d, input logic [8:0] e);
        fork
            far_i.send(b, d);
            pop(w);
        join
        chk("rx_word", e, w);
    endtask

    // s[1]: data-out stayed idle, s[0]: clear-to-send stayed low
    task automatic watch(input int n);
        s = 2'b11;
        repeat (n) begin
            @(negedge lk);
            s = s & {dout, ~cts};
        end
    endtask

    task automatic t_tx;
        do_reset(1'b1, 1'b1);
        for (int c = 0; c < 2; c++) begin
            fork
                push(c ? 8'h80 : 8'h01, c[0]);
                far_i.recv(c * 300, w);
            join
            chk("tx_frame", c ? 9'h180 : 9'h001, w);
        end
        $display("test tx done");
    endtask

    task automatic t_rx;
        rx1(8'h5a, 1'b0, 9'h05a);
        rx1(8'ha5, 1'b1, 9'h1a5);
        $display("test rx done");
    endtask

    task automatic t_hold;
        mode(8'h10);
        chk("held", 9'h001, {8'h00, held});
        push(8'h96, 1'b1);
        watch(40);
        chk("held_quiet", 9'h001, {8'h00, s[1]});
        mode(8'h00);
        far_i.recv(0, w);
        chk("held_sent", 9'h196, w);
        $display("test hold done");
    endtask

    task automatic t_full;
        far_i.send(8'h11, 1'b0);
        far_i.send(8'h22, 1'b1);
        watch(40);
        chk("full_cts", 9'h003, {7'h00, s});
        pop(w);
        chk("fifo_1", 9'h011, w);
        pop(w);
        chk("fifo_2", 9'h122, w);
        repeat (10) @(negedge lk);
        chk("cts_back", 9'h001, {8'h00, cts});
        $display("test full done");
    endtask

    task automatic t_route;
        do_reset(1'b1, 1'b0);
        chk("pins_b", 9'h001, {8'h00, pins_b});
        rx1(8'h3c, 1'b1, 9'h03c);
        do_reset(1'b0, 1'b1);
        rx1(8'hc3, 1'b0, 9'h1c3);
        do_reset(1'b0, 1'b0);
        tx_valid = 1'b1;
        repeat (30) @(negedge clk);
        chk("off", 9'h000, {6'h00, en, pins_b, tx_ready});
        tx_valid = 1'b0;
        $display("test route done");
    endtask

    initial begin
        #1_000_000;
        bad_count++;
        give_verdict();
    end

    initial begin
        t_tx();
        t_rx();
        t_hold();
        t_full();
        t_route();
        chk("far_fail", 9'h000, far_i.fails[8:0]);
        give_verdict();
    end
endmodule
